/* File: ibd_map.svh */
// Purpose: Constants for the instruction decoder.
// Assumes: Included by bare name.
// Notes: Step figures are the index of the last step.
`ifndef IBD_MAP_SVH
`define IBD_MAP_SVH
`define IBD_RESET_PC 12'h000
`define IBD_PTR_X_ADDR 8'h80
`define IBD_PTR_Y_ADDR 8'h81
`define IBD_SD_BASE 6'h20
`define IBD_ACC_ADDR 8'hFF
`define IBD_STACK_DEPTH 3'h6
`define IBD_LAST_SHORT 3'h1
`define IBD_LAST_STD 3'h3
`define IBD_LAST_BTEST 3'h4
`define IBD_LO_CALL 4'h1
`define IBD_LO_BTEST 4'h3
`define IBD_LO_SD 4'h5
`define IBD_LO_JUMP 4'h9
`define IBD_LO_BITOP 4'hB
`define IBD_LO_MISC 4'hD
`define IBD_BT_BIAS 12'h002
`endif

/* File: ibd_pkg.sv */
// Purpose: Types shared by the instruction decoder files.
// Assumes: Nothing.
// Notes: Codes of ibd_alu_t 0..7 follow opcode high bits 7..5.
package ibd_pkg;
    typedef enum logic [3:0] {
        CL_BRANCH = 4'h0, CL_CALL = 4'h1, CL_JUMP = 4'h2, CL_BTEST = 4'h3,
        CL_BITOP = 4'h4, CL_MEM = 4'h5, CL_LDIMEM = 4'h6, CL_ACC = 4'h7,
        CL_RET = 4'h8, CL_INTERRUPT_EXIT = 4'h9, CL_STOP = 4'hA, CL_WAIT = 4'hB,
        CL_ILLEGAL = 4'hC
    } ibd_class_t;
    typedef enum logic [2:0] {
        MD_NONE = 3'h0, MD_SD = 3'h1, MD_DIR = 3'h2, MD_IND = 3'h3, MD_IMM = 3'h4
    } ibd_mode_t;
    typedef enum logic [3:0] {
        AL_LD = 4'h0, AL_CP = 4'h1, AL_ADD = 4'h2, AL_INC = 4'h3,
        AL_STORE = 4'h4, AL_AND = 4'h5, AL_SUB = 4'h6, AL_DEC = 4'h7,
        AL_COM = 4'h8, AL_RLC = 4'h9, AL_BSET = 4'hA, AL_BCLR = 4'hB
    } ibd_alu_t;
    typedef enum logic {RUN_EXEC = 1'b0, RUN_HALT = 1'b1} ibd_run_t;
    typedef struct packed {
        ibd_class_t cls;
        ibd_mode_t mode;
        ibd_alu_t alu;
        logic [1:0] sd_idx;
        logic [2:0] bitn;
        logic [2:0] last;
        logic [1:0] len;
    } ibd_dec_t;
endpackage : ibd_pkg

/* File: ibd_if.sv */
// Purpose: Links the sequencer with its decoder and its arithmetic unit.
// Assumes: All signals are combinational.
// Notes: None.
`timescale 1ns/1ps
interface ibd_if;
    logic [7:0] opcode;
    ibd_pkg::ibd_dec_t dec;
    ibd_pkg::ibd_alu_t alu_op;
    logic [7:0] alu_a;
    logic [7:0] alu_b;
    logic alu_cin;
    logic [2:0] alu_bit;
    logic [7:0] alu_res;
    logic alu_cout;
    modport core(output opcode, alu_op, alu_a, alu_b, alu_cin, alu_bit,
                 input dec, alu_res, alu_cout);
    modport decoder(input opcode, output dec);
    modport alu(input alu_op, alu_a, alu_b, alu_cin, alu_bit, output alu_res, alu_cout);
endinterface : ibd_if

/* File: ibd_decode.sv */
// Purpose: Turns one opcode byte into class, mode, length and step count.
// Assumes: Opcode is the first byte of an instruction.
// Notes: Purely combinational.
`timescale 1ns/1ps
`include "ibd_map.svh"
module ibd_decode (
    // Decoder side of the link
    ibd_if.decoder port
);
    logic [3:0] lo;
    logic [3:0] hi;
    assign lo = port.opcode[3:0];
    assign hi = port.opcode[7:4];
    // Opcode map by low nibble, then high nibble.
    always_comb
    begin
        port.dec.cls = ibd_pkg::CL_ILLEGAL;
        port.dec.mode = ibd_pkg::MD_NONE;
        port.dec.alu = ibd_pkg::AL_LD;
        port.dec.sd_idx = hi[3:2];
        port.dec.bitn = {hi[1], hi[2], hi[3]};
        port.dec.last = `IBD_LAST_SHORT;
        port.dec.len = 2'h1;
        if (!lo[0])
        begin
            port.dec.cls = ibd_pkg::CL_BRANCH;
        end
        else if (lo == `IBD_LO_BTEST)
        begin
            port.dec.cls = ibd_pkg::CL_BTEST;
            port.dec.last = `IBD_LAST_BTEST;
            port.dec.len = 2'h3;
        end
        else if (lo == `IBD_LO_BITOP)
        begin
            port.dec.cls = ibd_pkg::CL_BITOP;
            port.dec.alu = hi[0] ? ibd_pkg::AL_BSET : ibd_pkg::AL_BCLR;
            port.dec.last = `IBD_LAST_STD;
            port.dec.len = 2'h2;
        end
        else if (lo == `IBD_LO_CALL || lo == `IBD_LO_JUMP)
        begin
            port.dec.cls = lo[3] ? ibd_pkg::CL_JUMP : ibd_pkg::CL_CALL;
            port.dec.last = `IBD_LAST_STD;
            port.dec.len = 2'h2;
        end
        else if (lo == `IBD_LO_SD)
        begin
            if (hi[0])
            begin
                port.dec.cls = ibd_pkg::CL_MEM;
                port.dec.mode = ibd_pkg::MD_SD;
                port.dec.alu = hi[1] ? ibd_pkg::AL_LD : ibd_pkg::AL_INC;
                port.dec.last = `IBD_LAST_STD;
            end
        end
        else if (lo == `IBD_LO_MISC)
        begin
            port.dec.last = `IBD_LAST_STD;
            case (hi)
                4'h0:
                begin
                    port.dec.cls = ibd_pkg::CL_LDIMEM;
                    port.dec.mode = ibd_pkg::MD_IMM;
                    port.dec.len = 2'h3;
                end
                4'h2:
                begin
                    port.dec.cls = ibd_pkg::CL_ACC;
                    port.dec.alu = ibd_pkg::AL_COM;
                end
                4'hA:
                begin
                    port.dec.cls = ibd_pkg::CL_ACC;
                    port.dec.alu = ibd_pkg::AL_RLC;
                end
                4'h4: port.dec.cls = ibd_pkg::CL_INTERRUPT_EXIT;
                4'h6: port.dec.cls = ibd_pkg::CL_STOP;
                4'hC: port.dec.cls = ibd_pkg::CL_RET;
                4'hE: port.dec.cls = ibd_pkg::CL_WAIT;
                4'h8: port.dec.cls = ibd_pkg::CL_ILLEGAL;
                default:
                begin
                    port.dec.cls = ibd_pkg::CL_MEM;
                    port.dec.mode = ibd_pkg::MD_SD;
                    port.dec.alu = hi[1] ? ibd_pkg::AL_STORE : ibd_pkg::AL_DEC;
                end
            endcase
            if (hi[2] && !hi[0] || hi == 4'h8)
            begin
                port.dec.last = `IBD_LAST_SHORT;
            end
        end
        else
        begin
            port.dec.alu = ibd_pkg::ibd_alu_t'({1'b0, hi[3:1]});
            port.dec.last = `IBD_LAST_STD;
            port.dec.cls = ibd_pkg::CL_MEM;
            if (!hi[0])
            begin
                port.dec.mode = ibd_pkg::MD_IND;
            end
            else if (lo[3])
            begin
                port.dec.mode = ibd_pkg::MD_DIR;
                port.dec.len = 2'h2;
            end
            else if (hi[3:1] == 3'h3 || hi[3:1] == 3'h4 || hi[3:1] == 3'h7)
            begin
                port.dec.cls = ibd_pkg::CL_ILLEGAL;
                port.dec.last = `IBD_LAST_SHORT;
            end
            else
            begin
                port.dec.mode = ibd_pkg::MD_IMM;
                port.dec.len = 2'h2;
            end
        end
    end
endmodule : ibd_decode

/* File: ibd_alu.sv */
// Purpose: Byte arithmetic, logic and bit operations with carry.
// Assumes: Operand a is the accumulator, b the memory operand.
// Notes: Purely combinational.
`timescale 1ns/1ps
module ibd_alu (
    // Arithmetic side of the link
    ibd_if.alu port
);
    logic [8:0] sum9;
    logic [8:0] dif9;
    logic [7:0] mask;
    assign sum9 = {1'b0, port.alu_a} + {1'b0, port.alu_b};
    assign dif9 = {1'b0, port.alu_a} - {1'b0, port.alu_b};
    assign mask = 8'h01 << port.alu_bit;
    // Result and carry out; carry passes through where untouched.
    always_comb
    begin
        port.alu_res = port.alu_b;
        port.alu_cout = port.alu_cin;
        case (port.alu_op)
            ibd_pkg::AL_CP, ibd_pkg::AL_SUB: {port.alu_cout, port.alu_res} = dif9;
            ibd_pkg::AL_ADD: {port.alu_cout, port.alu_res} = sum9;
            ibd_pkg::AL_INC: port.alu_res = port.alu_b + 8'h01;
            ibd_pkg::AL_DEC: port.alu_res = port.alu_b - 8'h01;
            ibd_pkg::AL_STORE: port.alu_res = port.alu_a;
            ibd_pkg::AL_AND: port.alu_res = port.alu_a & port.alu_b;
            ibd_pkg::AL_COM: {port.alu_cout, port.alu_res} = {port.alu_a[7], ~port.alu_a};
            ibd_pkg::AL_RLC: {port.alu_cout, port.alu_res} = {port.alu_a, port.alu_cin};
            ibd_pkg::AL_BSET: port.alu_res = port.alu_b | mask;
            ibd_pkg::AL_BCLR: port.alu_res = port.alu_b & ~mask;
            default: port.alu_res = port.alu_b;
        endcase
    end
endmodule : ibd_alu

/* File: ibd_core.sv */
// Purpose: Fetch, decode and execute sequencer of a small 8-bit core.
// Assumes: Program and data memories answer in the same cycle as the address.
// Notes: The accumulator also answers at data address FFh.
`timescale 1ns/1ps
`include "ibd_map.svh"
// Notes on behaviour
// - Bit-test branch is three bytes: opcode, tested address, signed displacement.
// - Indirect ops are one byte; pointer at 80h or 81h by opcode bit.
// - Inherent ops decode from the opcode alone, no operand bytes.
// - Only legal opcode cells decode; all other cells are illegal.
// - Constant to memory: three bytes, 4 cycles, flags kept.
// - Moves with accumulator take 4 cycles, set zero, keep carry.
// - Sum, compare, minus set zero and carry; mask sets zero only.
// - Count up or down short-direct locations 80h..83h, direct or indirect locations; zero flag only.
// - Invert and rotate act on accumulator, both flags, 4 cycles.
// - Flag branches: one byte, 2 cycles, flags kept, span -15..+16.
// - Bit branches take 5 cycles, keep zero, load carry.
// - Bit set and clear: two bytes, 4 cycles, any bit, flags kept.
// - Control ops are one byte, 2 cycles; only interrupt exit changes flags.
// - With watchdog selected, stop runs as wait.
// - Long jump and call: two bytes, 4 cycles, 12-bit target.
// - Low nibble 3 bit branch, B bit op; high bits give bit number.
// - Even low nibble short branch; 1 is call, 9 is long jump.
// - Jump target is four opcode bits above the following byte.
// - Opcode bit picks forward or backward; four bits give the span.
// - Unassigned opcode cells never act as a valid operation.
module ibd_core (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Program memory
    output logic [11:0] prog_addr,
    input wire logic [7:0] prog_data,
    // Data space
    output logic [7:0] data_addr,
    output logic data_we,
    output logic [7:0] data_wdata,
    input wire logic [7:0] data_rdata,
    // Core control and status
    input wire logic watchdog_sel,
    input wire logic wake,
    output logic flag_z,
    output logic flag_c,
    output logic wait_state,
    output logic stop_state,
    output logic illegal_op
);
    ibd_if link ();
    ibd_pkg::ibd_dec_t dec;
    ibd_pkg::ibd_run_t run_reg;
    logic [2:0] step_reg;
    logic [11:0] pc_reg;
    logic [11:0] pcn_reg;
    logic [11:0] prog_addr_reg;
    logic [7:0] op_reg;
    logic [7:0] b2_reg;
    logic [7:0] opnd_addr_reg;
    logic [7:0] acc_reg;
    logic z_reg;
    logic c_reg;
    logic sz_reg;
    logic sc_reg;
    logic [11:0] stack_mem [0:5];
    logic [2:0] sp_reg;
    logic [7:0] data_addr_reg;
    logic data_we_reg;
    logic [7:0] data_wdata_reg;
    logic wait_reg;
    logic stop_reg;
    logic illegal_reg;
    logic exec;
    logic last;
    logic [3:0] hi;
    logic [3:0] lo;
    logic [7:0] operand;
    logic [7:0] opnd_addr_comb;
    logic br_taken;
    logic [11:0] br_target;
    logic bit_hit;
    logic [11:0] bt_target;
    logic [2:0] top_idx;
    logic writes_mem;
    logic acc_alias;
    logic [7:0] wval;

    ibd_decode u_decode (
        .port(link.decoder)
    );

    ibd_alu u_alu (
        .port(link.alu)
    );

    // Decode the live byte in the first step, the held opcode afterwards.
    assign exec = (run_reg == ibd_pkg::RUN_EXEC);
    assign link.opcode = (step_reg == 3'h0) ? prog_data : op_reg;
    assign dec = link.dec;
    assign last = (step_reg == dec.last);
    assign hi = link.opcode[7:4];
    assign lo = link.opcode[3:0];

    // Immediate values come from the second byte; FFh reads the accumulator.
    assign acc_alias = (opnd_addr_reg == `IBD_ACC_ADDR);
    assign operand = (dec.mode == ibd_pkg::MD_IMM) ? b2_reg :
                     acc_alias ? acc_reg : data_rdata;
    assign link.alu_op = dec.alu;
    assign link.alu_a = acc_reg;
    assign link.alu_b = operand;
    assign link.alu_cin = c_reg;
    assign link.alu_bit = dec.bitn;

    // Operand address issued in the second step.
    always_comb
    begin
        case (dec.mode)
            ibd_pkg::MD_SD: opnd_addr_comb = {`IBD_SD_BASE, dec.sd_idx};
            ibd_pkg::MD_IND: opnd_addr_comb = data_rdata;
            default: opnd_addr_comb = prog_data;
        endcase
    end

    // Short branch condition and target.
    always_comb
    begin
        case (lo[2:1])
            2'b00: br_taken = !z_reg;
            2'b01: br_taken = !c_reg;
            2'b10: br_taken = z_reg;
            default: br_taken = c_reg;
        endcase
    end
    assign br_target = lo[3] ? pc_reg - {8'h00, hi} : pc_reg + {8'h00, hi} + 12'h001;

    // Bit test: sense from opcode, displacement is the third byte.
    assign bit_hit = (operand[dec.bitn] == hi[0]);
    assign bt_target = pc_reg + `IBD_BT_BIAS + {{4{prog_data[7]}}, prog_data};
    assign top_idx = (sp_reg == 3'h0) ? 3'h0 : sp_reg - 3'h1;

    // Memory writes and the value written.
    assign writes_mem = (dec.cls == ibd_pkg::CL_BITOP) || (dec.cls == ibd_pkg::CL_LDIMEM) ||
                        (dec.cls == ibd_pkg::CL_MEM && (dec.alu == ibd_pkg::AL_INC ||
                         dec.alu == ibd_pkg::AL_DEC || dec.alu == ibd_pkg::AL_STORE));
    assign wval = (dec.cls == ibd_pkg::CL_LDIMEM) ? prog_data : link.alu_res;

    // Step counter and the halt states.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            run_reg <= ibd_pkg::RUN_EXEC;
            step_reg <= 3'h0;
            wait_reg <= 1'b0;
            stop_reg <= 1'b0;
        end
        else if (!exec)
        begin
            if (wake)
            begin
                run_reg <= ibd_pkg::RUN_EXEC;
                wait_reg <= 1'b0;
                stop_reg <= 1'b0;
            end
        end
        else if (last)
        begin
            step_reg <= 3'h0;
            if (dec.cls == ibd_pkg::CL_STOP || dec.cls == ibd_pkg::CL_WAIT)
            begin
                run_reg <= ibd_pkg::RUN_HALT;
                stop_reg <= (dec.cls == ibd_pkg::CL_STOP) && !watchdog_sel;
                wait_reg <= (dec.cls == ibd_pkg::CL_WAIT) || watchdog_sel;
            end
        end
        else
        begin
            step_reg <= step_reg + 3'h1;
        end
    end

    // Opcode, second byte and operand address holding.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            op_reg <= 8'h00;
            b2_reg <= 8'h00;
            opnd_addr_reg <= 8'h00;
        end
        else if (exec && step_reg == 3'h0)
        begin
            op_reg <= prog_data;
        end
        else if (exec && step_reg == 3'h1)
        begin
            b2_reg <= prog_data;
            opnd_addr_reg <= opnd_addr_comb;
        end
    end

    // Next program address, set in the first step; jumps and calls redo it in the second, bit tests in the third.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pcn_reg <= `IBD_RESET_PC;
        end
        else if (exec && step_reg == 3'h0)
        begin
            case (dec.cls)
                ibd_pkg::CL_BRANCH: pcn_reg <= br_taken ? br_target : pc_reg + 12'h001;
                ibd_pkg::CL_RET, ibd_pkg::CL_INTERRUPT_EXIT: pcn_reg <= stack_mem[top_idx];
                default: pcn_reg <= pc_reg + {10'h000, dec.len};
            endcase
        end
        else if (exec && step_reg == 3'h1)
        begin
            if (dec.cls == ibd_pkg::CL_CALL || dec.cls == ibd_pkg::CL_JUMP)
            begin
                pcn_reg <= {op_reg[7:4], prog_data};
            end
        end
        else if (exec && step_reg == 3'h2 && dec.cls == ibd_pkg::CL_BTEST)
        begin
            pcn_reg <= bit_hit ? bt_target : pcn_reg;
        end
    end

    // Program counter and fetch address.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pc_reg <= `IBD_RESET_PC;
            prog_addr_reg <= `IBD_RESET_PC;
        end
        else if (exec && last)
        begin
            pc_reg <= pcn_reg;
            prog_addr_reg <= pcn_reg;
        end
        else if (exec && step_reg == 3'h0)
        begin
            prog_addr_reg <= pc_reg + 12'h001;
        end
        else if (exec && step_reg == 3'h1)
        begin
            prog_addr_reg <= pc_reg + 12'h002;
        end
    end

    // Data space address and one-cycle write strobe.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            data_addr_reg <= 8'h00;
            data_we_reg <= 1'b0;
            data_wdata_reg <= 8'h00;
        end
        else
        begin
            data_we_reg <= 1'b0;
            if (exec && step_reg == 3'h0 && dec.mode == ibd_pkg::MD_IND)
            begin
                data_addr_reg <= lo[3] ? `IBD_PTR_Y_ADDR : `IBD_PTR_X_ADDR;
            end
            else if (exec && step_reg == 3'h1)
            begin
                data_addr_reg <= opnd_addr_comb;
            end
            else if (exec && step_reg == 3'h2 && writes_mem && !acc_alias)
            begin
                data_we_reg <= 1'b1;
                data_wdata_reg <= wval;
            end
        end
    end

    // Accumulator and flags, settled in the third step; interrupt exit restores the flags in the first.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc_reg <= 8'h00;
            z_reg <= 1'b0;
            c_reg <= 1'b0;
        end
        else if (exec && step_reg == 3'h0 && dec.cls == ibd_pkg::CL_INTERRUPT_EXIT)
        begin
            z_reg <= sz_reg;
            c_reg <= sc_reg;
        end
        else if (exec && step_reg == 3'h2)
        begin
            if (dec.cls == ibd_pkg::CL_BTEST)
            begin
                c_reg <= operand[dec.bitn];
            end
            if (dec.cls == ibd_pkg::CL_MEM || dec.cls == ibd_pkg::CL_ACC)
            begin
                z_reg <= (link.alu_res == 8'h00);
            end
            if (dec.cls == ibd_pkg::CL_ACC || (dec.cls == ibd_pkg::CL_MEM &&
                (dec.alu == ibd_pkg::AL_CP || dec.alu == ibd_pkg::AL_ADD ||
                 dec.alu == ibd_pkg::AL_SUB)))
            begin
                c_reg <= link.alu_cout;
            end
            if (dec.cls == ibd_pkg::CL_ACC || (dec.cls == ibd_pkg::CL_MEM &&
                (dec.alu == ibd_pkg::AL_LD || dec.alu == ibd_pkg::AL_ADD ||
                 dec.alu == ibd_pkg::AL_AND || dec.alu == ibd_pkg::AL_SUB)))
            begin
                acc_reg <= link.alu_res;
            end
            else if (writes_mem && acc_alias)
            begin
                acc_reg <= wval;
            end
        end
    end

    // Return stack of six entries; flags are saved with each call.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sp_reg <= 3'h0;
            sz_reg <= 1'b0;
            sc_reg <= 1'b0;
            for (int i = 0; i < 6; i++)
            begin
                stack_mem[i] <= `IBD_RESET_PC;
            end
        end
        else if (exec && step_reg == 3'h1 && dec.cls == ibd_pkg::CL_CALL)
        begin
            sz_reg <= z_reg;
            sc_reg <= c_reg;
            if (sp_reg != `IBD_STACK_DEPTH)
            begin
                stack_mem[sp_reg] <= pc_reg + 12'h002;
                sp_reg <= sp_reg + 3'h1;
            end
        end
        else if (exec && step_reg == 3'h0 && sp_reg != 3'h0 &&
                 (dec.cls == ibd_pkg::CL_RET || dec.cls == ibd_pkg::CL_INTERRUPT_EXIT))
        begin
            sp_reg <= sp_reg - 3'h1;
        end
    end

    // One-cycle mark for an opcode from an unassigned cell.
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            illegal_reg <= 1'b0;
        end
        else
        begin
            illegal_reg <= exec && step_reg == 3'h0 && dec.cls == ibd_pkg::CL_ILLEGAL;
        end
    end

    // Outputs straight from their flip-flops.
    assign prog_addr = prog_addr_reg;
    assign data_addr = data_addr_reg;
    assign data_we = data_we_reg;
    assign data_wdata = data_wdata_reg;
    assign flag_z = z_reg;
    assign flag_c = c_reg;
    assign wait_state = wait_reg;
    assign stop_state = stop_reg;
    assign illegal_op = illegal_reg;
endmodule : ibd_core

/* File: ibd_mem_model.sv */
// Purpose: Program and data memory beside the core.
// Assumes: Reads answer in the cycle of the address.
// Notes: The bench loads both memories.
`timescale 1ns/1ps
module ibd_mem_model (
    // Clock
    input wire logic core_clk,
    // Program side
    input wire logic [11:0] prog_addr,
    output logic [7:0] prog_data,
    // Data side
    input wire logic [7:0] data_addr,
    input wire logic data_we,
    input wire logic [7:0] data_wdata,
    output logic [7:0] data_rdata
);
    logic [7:0] rom [4096];
    logic [7:0] ram [256];
    // Both memories read combinationally.
    assign prog_data = rom[prog_addr];
    assign data_rdata = ram[data_addr];
    // A strobed byte lands at the edge ending its cycle.
    always @(posedge core_clk)
    begin
        if (data_we)
            ram[data_addr] <= data_wdata;
    end
endmodule : ibd_mem_model

/* File: ibd_core_assertions.sv */
// Purpose: Timing checks on the core's ports.
// Assumes: Bound to ibd_core.
// Notes: One clock domain.
`timescale 1ns/1ps
module ibd_core_assertions (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Buses
    input wire logic [11:0] prog_addr,
    input wire logic [7:0] data_addr,
    input wire logic data_we,
    // Control and status
    input wire logic watchdog_sel,
    input wire logic wake,
    input wire logic flag_z,
    input wire logic flag_c,
    input wire logic wait_state,
    input wire logic stop_state,
    input wire logic illegal_op
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // Core is halted and nobody wakes it.
    sequence s_parked;
        (wait_state || stop_state) && !wake;
    endsequence
    a_we_single: assert property (data_we |=> !data_we)
        else $error("write strobe too long");
    a_acc_quiet: assert property (data_we |-> data_addr != 8'hFF)
        else $error("strobe to accumulator");
    a_write_carry: assert property (data_we |-> flag_c == $past(flag_c, 2))
        else $error("carry moved by a write");
    a_bad_single: assert property (illegal_op |=> !illegal_op)
        else $error("illegal pulse too long");
    a_bad_flags: assert property (illegal_op |-> $stable({flag_z, flag_c}))
        else $error("flags moved by illegal op");
    a_wdog_stop: assert property ($rose(stop_state) |-> !$past(watchdog_sel))
        else $error("stop entered under watchdog");
    a_halt_one: assert property (!(wait_state && stop_state))
        else $error("two halt states");
    a_park_pc: assert property (s_parked |=> $stable(prog_addr))
        else $error("fetch moved while halted");
    a_park_flags: assert property (s_parked |=> $stable({flag_z, flag_c}))
        else $error("flags moved while halted");
endmodule : ibd_core_assertions

/* File: ibd_core_tb.sv */
// Purpose: Self-checking bench for the instruction sequencer.
// Assumes: The memory model holds each program.
// Notes: Every scenario reboots the core.
`timescale 1ns/1ps
module ibd_core_tb;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic watchdog_sel = 1'b0;
    logic wake = 1'b0;
    logic [11:0] prog_addr;
    logic [7:0] prog_data, data_addr, data_wdata, data_rdata;
    logic data_we, flag_z, flag_c, wait_state, stop_state, illegal_op;
    int n_errors = 0;
    int cmp_count = 0;
    // Core clock, 100 ns period.
    initial forever #50 core_clk = ~core_clk;
    // Core under test and its memories.
    ibd_core i_dut (.core_clk(core_clk), .rst_n(rst_n), .prog_addr(prog_addr),
        .prog_data(prog_data), .data_addr(data_addr), .data_we(data_we),
        .data_wdata(data_wdata), .data_rdata(data_rdata), .watchdog_sel(watchdog_sel),
        .wake(wake), .flag_z(flag_z), .flag_c(flag_c), .wait_state(wait_state),
        .stop_state(stop_state), .illegal_op(illegal_op));
    ibd_mem_model i_mem (.core_clk(core_clk), .prog_addr(prog_addr), .prog_data(prog_data),
        .data_addr(data_addr), .data_we(data_we), .data_wdata(data_wdata),
        .data_rdata(data_rdata));
    // Prints the verdict and ends the run.
    task automatic wrap_up;
        if (n_errors == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : wrap_up
    // Compares one result and counts it.
    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask : chk
    // Loads a program, then holds reset for 4 cycles.
    task automatic boot(input logic [7:0] p [$]);
        foreach (i_mem.rom[i])
            i_mem.rom[i] = 8'h00;
        foreach (p[i])
            i_mem.rom[i] = p[i];
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        @(negedge core_clk);
    endtask : boot
    // Lets n edges pass; outputs are settled on return.
    task automatic run(input int n);
        repeat (n) @(negedge core_clk);
    endtask : run
    // Constant to memory, load and store with the accumulator.
    task automatic t_move;
        i_mem.ram[8'h31] = 8'hAA;
        boot('{8'h0D, 8'h30, 8'h00, 8'h1F, 8'h30, 8'h9F, 8'h31});
        run(4);
        chk("pc", 12'h003, prog_addr);
        chk("ram30", 12'h000, i_mem.ram[8'h30]);
        chk("z", 12'h000, flag_z);
        run(4);
        chk("pc", 12'h005, prog_addr);
        chk("z", 12'h001, flag_z);
        run(4);
        chk("ram31", 12'h000, i_mem.ram[8'h31]);
    endtask : t_move
    // Sum with carry out, then a taken forward short branch.
    task automatic t_arith;
        boot('{8'h17, 8'hF0, 8'h57, 8'h10, 8'h34});
        run(8);
        chk("z", 12'h001, flag_z);
        chk("c", 12'h001, flag_c);
        run(2);
        chk("pc", 12'h008, prog_addr);
        chk("c", 12'h001, flag_c);
    endtask : t_arith
    // Long jump to a 12-bit target.
    task automatic t_jump;
        boot('{8'h39, 8'h45});
        run(4);
        chk("pc", 12'h345, prog_addr);
    endtask : t_jump
    // Set bit 7, then branch on a set bit 0.
    task automatic t_bits;
        i_mem.ram[8'h40] = 8'h01;
        i_mem.ram[8'h41] = 8'h00;
        boot('{8'hFB, 8'h41, 8'h13, 8'h40, 8'h10});
        run(4);
        chk("ram41", 12'h080, i_mem.ram[8'h41]);
        run(5);
        chk("pc", 12'h014, prog_addr);
        chk("c", 12'h001, flag_c);
    endtask : t_bits
    // Call, interrupt exit, illegal cell, then an indirect load.
    task automatic t_call;
        i_mem.ram[8'h80] = 8'h50;
        i_mem.ram[8'h50] = 8'h00;
        boot('{8'h01, 8'h04, 8'h77, 8'h07, 8'h4D});
        run(6);
        chk("pc", 12'h002, prog_addr);
        run(2);
        chk("pc", 12'h003, prog_addr);
        run(4);
        chk("z", 12'h001, flag_z);
    endtask : t_call
    // Plain stop, then illegal cell, stop under watchdog, then wake.
    task automatic t_halt;
        int k;
        boot('{8'h6D});
        run(2);
        chk("stop", 12'h001, stop_state);
        @(posedge core_clk);
        watchdog_sel <= 1'b1;
        boot('{8'h05, 8'h6D});
        run(1);
        chk("bad", 12'h001, illegal_op);
        run(3);
        chk("wait", 12'h001, wait_state);
        chk("stop", 12'h000, stop_state);
        @(posedge core_clk);
        wake <= 1'b1;
        for (k = 0; k < 8 && wait_state !== 1'b0; k++)
            @(negedge core_clk);
        chk("wake", 12'h000, wait_state);
        if (k == 8)
            wrap_up();
        @(posedge core_clk);
        wake <= 1'b0;
    endtask : t_halt
    // Main sequence.
    initial
    begin
        t_move();
        t_arith();
        t_jump();
        t_bits();
        t_call();
        t_halt();
        wrap_up();
    end
endmodule : ibd_core_tb
bind ibd_core ibd_core_assertions i_chk (
    .core_clk(core_clk), .rst_n(rst_n), .prog_addr(prog_addr), .data_addr(data_addr),
    .data_we(data_we), .watchdog_sel(watchdog_sel), .wake(wake), .flag_z(flag_z),
    .flag_c(flag_c), .wait_state(wait_state), .stop_state(stop_state), .illegal_op(illegal_op)
);
